/* core/channel_gate.sv */
`default_nettype none
module channel_gate (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic enable_in,
  input  wire logic allow,
  output logic      channel_on,
  output logic      soft_start
);
  typedef struct packed {
    logic on;
    logic start;
  } gate_s;

  gate_s g_r;
  gate_s g_nxt;

  always_comb begin
    g_nxt.on    = enable_in & allow;
    g_nxt.start = g_nxt.on & ~g_r.on;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      g_r <= '0;
    end else begin
      g_r <= g_nxt;
    end
  end

  assign channel_on = g_r.on;
  assign soft_start = g_r.start;
endmodule
`default_nettype wire

/* core/pmu_pkg.sv */
`default_nettype none
package pmu_pkg;
  // ============================================================
  // Register map
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET  = 8'h04;
  localparam logic [7:0] EVENT_OFFSET   = 8'h08;
  localparam logic [7:0] MASK_OFFSET    = 8'h0C;

  // ============================================================
  // Field positions
  localparam int CTRL_HIGH_UVLO_BIT = 0;
  localparam int CTRL_ORDER_LSB     = 1;
  localparam int STAT_CHANNEL_LSB   = 0;
  localparam int STAT_THERMAL_BIT   = 3;
  localparam int STAT_UVLO_BIT      = 4;
  localparam int STAT_SEQ_BUSY_BIT  = 5;
  localparam int STAT_FORCED_BIT    = 6;
  localparam int STAT_BURST_BIT     = 7;
  localparam int EV_THERMAL_BIT     = 0;
  localparam int EV_UVLO_BIT        = 1;
  localparam int EV_RESTART_BIT     = 2;
  localparam int EVENT_WIDTH        = 3;

  // ============================================================
  // Reset values
  localparam logic             CTRL_HIGH_UVLO_RESET = 1'b0;
  localparam logic [1:0]       ORDER_RESET          = 2'h0;
  localparam logic [EVENT_WIDTH-1:0] EVENT_RESET    = 3'h0;
  localparam logic [EVENT_WIDTH-1:0] MASK_RESET     = 3'h0;
  localparam logic [2:0]       RELEASE_RESET        = 3'h7;

  // ============================================================
  // Channels and restart orders
  localparam int NUM_CHANNELS = 3;
  localparam int CH_SWITCHER  = 0;
  localparam int CH_LINEAR_A  = 1;
  localparam int CH_LINEAR_B  = 2;
  localparam logic [2:0] MASK_SWITCHER = 3'h1;
  localparam logic [2:0] MASK_LINEAR_A = 3'h2;
  localparam logic [2:0] MASK_LINEAR_B = 3'h4;
  localparam logic [2:0] MASK_ALL      = 3'h7;
  localparam logic [1:0] ORDER_A_B_SW  = 2'h0;
  localparam logic [1:0] ORDER_SW_A_B  = 2'h1;
  localparam logic [1:0] ORDER_A_SW_B  = 2'h2;
  localparam logic [1:0] ORDER_ALL     = 2'h3;
  localparam logic [1:0] LAST_STEP     = 2'h2;

  // ============================================================
  // Timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int SEQUENCE_GAP_MS     = 2;
  localparam int SEQUENCE_GAP_CYCLES = SEQUENCE_GAP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int GAP_COUNT_W         = 18;

  // ============================================================
  // Bus
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_GAP  = 2'b10
  } seq_state_e;
endpackage
`default_nettype wire

/* core/regulator_enable_sequencer.sv */
`default_nettype none
// Behaviour
// - One enable pin per channel, fixed mapping
// - Enable high turns channel on, low off
// - Every turn-on starts a soft-start ramp
// - Mode high: forced fixed-frequency PWM
// - Mode low: PWM, burst below light-load threshold
// - Over-temperature turns all channels off
// - Stay off until temperature below recovery point
// - Leaving thermal shutdown gives fresh soft start
// - Undervoltage lockout shuts all channels down
// - Lockout opens main switch and rectifier
// - Supply back above threshold re-allows channels
// - High-threshold variant selects other trip level
// - Power-cycle event restarts channels in order; ORDER_ALL releases all channels at once
// - Two milliseconds between successive channel starts
// - Order select decodes four start orders
module regulator_enable_sequencer
  import pmu_pkg::*;
#(
  parameter int GAP_CYCLES = SEQUENCE_GAP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        switcher_enable_in,
  input  wire logic        linear_a_enable_in,
  input  wire logic        linear_b_enable_in,
  input  wire logic        mode_in,
  input  wire logic        light_load_in,
  input  wire logic        junction_above_shutdown,
  input  wire logic        junction_below_recovery,
  input  wire logic        supply_below_std_trip,
  input  wire logic        supply_below_high_trip,
  input  wire logic        power_cycle_event,
  output logic             switcher_on,
  output logic             linear_reg_a_on,
  output logic             linear_reg_b_on,
  output logic             switcher_soft_start,
  output logic             linear_reg_a_soft_start,
  output logic             linear_reg_b_soft_start,
  output logic             main_switch_enable,
  output logic             sync_rect_enable,
  output logic             forced_pwm,
  output logic             burst_mode,
  output logic             irq
);
  // ============================================================
  // State
  typedef struct packed {
    logic                   high_uvlo;
    logic [1:0]             order;
    logic [EVENT_WIDTH-1:0] events;
    logic [EVENT_WIDTH-1:0] mask;
    logic                   thermal_off;
    logic                   uvlo;
    logic                   wr_pending;
    logic [7:0]             wr_addr;
    logic [31:0]            rdata;
    logic                   ready;
    logic                   irq;
    logic                   main_sw;
    logic                   sync_rect;
    logic                   forced;
    logic                   burst;
  } top_s;

  top_s s_r;
  top_s s_nxt;

  logic [NUM_CHANNELS-1:0] enable_in;
  logic [NUM_CHANNELS-1:0] allow;
  logic [NUM_CHANNELS-1:0] channel_on;
  logic [NUM_CHANNELS-1:0] soft_start;
  logic [2:0]              release_mask;
  logic                    seq_busy;
  logic                    seq_done;

  // ============================================================
  // Channels
  always_comb begin
    enable_in[CH_SWITCHER] = switcher_enable_in;
    enable_in[CH_LINEAR_A] = linear_a_enable_in;
    enable_in[CH_LINEAR_B] = linear_b_enable_in;
  end

  generate
    for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_ch
      assign allow[i] = ~s_r.thermal_off & ~s_r.uvlo & release_mask[i];
      channel_gate u_gate (
        .clk        (clk),
        .resetn     (resetn),
        .enable_in  (enable_in[i]),
        .allow      (allow[i]),
        .channel_on (channel_on[i]),
        .soft_start (soft_start[i])
      );
    end
  endgenerate

  restart_sequencer #(
    .GAP_CYCLES (GAP_CYCLES),
    .COUNT_W    (GAP_COUNT_W)
  ) u_seq (
    .clk           (clk),
    .resetn        (resetn),
    .restart_event (power_cycle_event),
    .order_select  (s_r.order),
    .release_mask  (release_mask),
    .busy          (seq_busy),
    .done          (seq_done)
  );

  // ============================================================
  // Next state
  logic                   addr_phase;
  logic                   mapped;
  logic [EVENT_WIDTH-1:0] ev_set;
  logic [EVENT_WIDTH-1:0] ev_clr;
  logic                   sw_on_nxt;
  logic [31:0]            rd;

  always_comb begin
    s_nxt      = s_r;
    ev_clr     = '0;
    ev_set     = '0;
    rd         = 32'h0;
    s_nxt.ready = 1'b1;

    // Thermal shutdown with hysteresis
    if (junction_above_shutdown) begin
      s_nxt.thermal_off = 1'b1;
    end else if (junction_below_recovery) begin
      s_nxt.thermal_off = 1'b0;
    end

    // Lockout level from the selected trip comparator
    s_nxt.uvlo = s_r.high_uvlo ? supply_below_high_trip : supply_below_std_trip;

    // Switcher power stage follows the gated channel state
    sw_on_nxt       = switcher_enable_in & ~s_nxt.thermal_off & ~s_nxt.uvlo & release_mask[CH_SWITCHER];
    s_nxt.main_sw   = sw_on_nxt;
    s_nxt.sync_rect = sw_on_nxt;
    s_nxt.forced    = mode_in;
    s_nxt.burst     = ~mode_in & light_load_in & sw_on_nxt;

    // Bus write data phase
    addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);
    if (s_r.wr_pending) begin
      unique case (s_r.wr_addr)
        CONTROL_OFFSET: begin
          s_nxt.high_uvlo = hwdata[CTRL_HIGH_UVLO_BIT];
          s_nxt.order     = hwdata[CTRL_ORDER_LSB +: 2];
        end
        EVENT_OFFSET: ev_clr = hwdata[EVENT_WIDTH-1:0];
        MASK_OFFSET:  s_nxt.mask = hwdata[EVENT_WIDTH-1:0];
        default: ;
      endcase
    end

    // Sticky events, a new event wins over a clear
    ev_set[EV_THERMAL_BIT] = s_nxt.thermal_off & ~s_r.thermal_off;
    ev_set[EV_UVLO_BIT]    = s_nxt.uvlo & ~s_r.uvlo;
    ev_set[EV_RESTART_BIT] = seq_done;
    s_nxt.events = (s_r.events & ~ev_clr) | ev_set;
    s_nxt.irq    = |(s_nxt.events & s_nxt.mask);

    // Bus address phase
    mapped           = (haddr[31:4] == 28'h0);
    s_nxt.wr_pending = addr_phase & hwrite & mapped;
    s_nxt.wr_addr    = {haddr[7:2], 2'h0};
    if (addr_phase & ~hwrite & mapped) begin
      unique case ({haddr[7:2], 2'h0})
        CONTROL_OFFSET: begin
          rd[CTRL_HIGH_UVLO_BIT]       = s_nxt.high_uvlo;
          rd[CTRL_ORDER_LSB +: 2]      = s_nxt.order;
        end
        STATUS_OFFSET: begin
          rd[STAT_CHANNEL_LSB +: NUM_CHANNELS] = channel_on;
          rd[STAT_THERMAL_BIT]  = s_r.thermal_off;
          rd[STAT_UVLO_BIT]     = s_r.uvlo;
          rd[STAT_SEQ_BUSY_BIT] = seq_busy;
          rd[STAT_FORCED_BIT]   = s_r.forced;
          rd[STAT_BURST_BIT]    = s_r.burst;
        end
        EVENT_OFFSET: rd[EVENT_WIDTH-1:0] = s_nxt.events;
        MASK_OFFSET:  rd[EVENT_WIDTH-1:0] = s_nxt.mask;
        default: ;
      endcase
    end
    s_nxt.rdata = rd;
  end

  // ============================================================
  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{high_uvlo: CTRL_HIGH_UVLO_RESET, order: ORDER_RESET, events: EVENT_RESET,
               mask: MASK_RESET, thermal_off: 1'b0, uvlo: 1'b0, wr_pending: 1'b0,
               wr_addr: 8'h00, rdata: 32'h0, ready: 1'b1, irq: 1'b0, main_sw: 1'b0,
               sync_rect: 1'b0, forced: 1'b0, burst: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ============================================================
  // Outputs
  assign hreadyout               = s_r.ready;
  assign hrdata                  = s_r.rdata;
  assign hresp                   = 1'b0;
  assign switcher_on             = channel_on[CH_SWITCHER];
  assign linear_reg_a_on         = channel_on[CH_LINEAR_A];
  assign linear_reg_b_on         = channel_on[CH_LINEAR_B];
  assign switcher_soft_start     = soft_start[CH_SWITCHER];
  assign linear_reg_a_soft_start = soft_start[CH_LINEAR_A];
  assign linear_reg_b_soft_start = soft_start[CH_LINEAR_B];
  assign main_switch_enable      = s_r.main_sw;
  assign sync_rect_enable        = s_r.sync_rect;
  assign forced_pwm              = s_r.forced;
  assign burst_mode              = s_r.burst;
  assign irq                     = s_r.irq;
endmodule
`default_nettype wire

/* core/restart_sequencer.sv */
`default_nettype none
module restart_sequencer
  import pmu_pkg::*;
#(
  parameter int GAP_CYCLES = SEQUENCE_GAP_CYCLES,
  parameter int COUNT_W    = GAP_COUNT_W
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       restart_event,
  input  wire logic [1:0] order_select,
  output logic      [2:0] release_mask,
  output logic            busy,
  output logic            done
);
  typedef struct packed {
    seq_state_e         state;
    logic [1:0]         order;
    logic [1:0]         step;
    logic [COUNT_W-1:0] count;
    logic [2:0]         release_mask;
    logic               done;
  } seq_s;

  seq_s s_r;
  seq_s s_nxt;

  localparam logic [COUNT_W-1:0] GAP_LAST = COUNT_W'(GAP_CYCLES - 1);

  // Channel started at a given step of a given order
  function automatic logic [2:0] order_mask(input logic [1:0] sel, input logic [1:0] step);
    logic [2:0] m;
    m = MASK_ALL;
    unique case (sel)
      ORDER_A_B_SW: m = (step == 2'h0) ? MASK_LINEAR_A : (step == 2'h1) ? MASK_LINEAR_B : MASK_SWITCHER;
      ORDER_SW_A_B: m = (step == 2'h0) ? MASK_SWITCHER : (step == 2'h1) ? MASK_LINEAR_A : MASK_LINEAR_B;
      ORDER_A_SW_B: m = (step == 2'h0) ? MASK_LINEAR_A : (step == 2'h1) ? MASK_SWITCHER : MASK_LINEAR_B;
      ORDER_ALL:    m = MASK_ALL;
    endcase
    return m;
  endfunction

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (restart_event) begin
      // Later slots held off, first slot released at once
      s_nxt.order        = order_select;
      s_nxt.release_mask = order_mask(order_select, 2'h0);
      s_nxt.step         = 2'h1;
      s_nxt.count        = '0;
      if (order_select == ORDER_ALL) begin
        s_nxt.state = SEQ_IDLE;
        s_nxt.done  = 1'b1;
      end else begin
        s_nxt.state = SEQ_GAP;
      end
    end else begin
      unique case (s_r.state)
        SEQ_IDLE: s_nxt.count = '0;
        SEQ_GAP: begin
          if (s_r.count == GAP_LAST) begin
            // Next slot released even if its enable is low
            s_nxt.release_mask = s_r.release_mask | order_mask(s_r.order, s_r.step);
            s_nxt.count        = '0;
            if (s_r.step == LAST_STEP) begin
              s_nxt.state = SEQ_IDLE;
              s_nxt.done  = 1'b1;
            end else begin
              s_nxt.step = s_r.step + 2'h1;
            end
          end else begin
            s_nxt.count = s_r.count + COUNT_W'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{state: SEQ_IDLE, order: ORDER_RESET, step: 2'h0, count: '0,
               release_mask: RELEASE_RESET, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign release_mask = s_r.release_mask;
  assign busy         = (s_r.state == SEQ_GAP);
  assign done         = s_r.done;
endmodule
`default_nettype wire

/* tb/host_model.sv */
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic [2:0] en_cmd,
  input  var  int         temp_c,
  input  var  int         supply_mv,
  output logic            switcher_enable_in,
  output logic            linear_a_enable_in,
  output logic            linear_b_enable_in,
  output logic            junction_above_shutdown,
  output logic            junction_below_recovery,
  output logic            supply_below_std_trip,
  output logic            supply_below_high_trip
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk) begin
    {linear_b_enable_in, linear_a_enable_in, switcher_enable_in} <= en_cmd;
  end
  assign junction_above_shutdown = temp_c > 150;
  assign junction_below_recovery = temp_c < 130;
  assign supply_below_std_trip   = supply_mv < 2150;
  assign supply_below_high_trip  = supply_mv < 3650;
endmodule
`default_nettype wire

/* tb/res_properties.sv */
`default_nettype none
module res_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic switcher_enable_in,
  input wire logic mode_in,
  input wire logic light_load_in,
  input wire logic junction_above_shutdown,
  input wire logic junction_below_recovery,
  input wire logic supply_below_std_trip,
  input wire logic switcher_on,
  input wire logic linear_reg_a_on,
  input wire logic linear_reg_b_on,
  input wire logic switcher_soft_start,
  input wire logic main_switch_enable,
  input wire logic sync_rect_enable,
  input wire logic forced_pwm,
  input wire logic burst_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  wire any_on = switcher_on | linear_reg_a_on | linear_reg_b_on;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ============================================================
  // Channel gating
  en_gate_a: assert property ($rose(switcher_on) |-> $past(switcher_enable_in))
    else $error("switcher came on without its enable");
  soft_start_a: assert property ($rose(switcher_on) |-> switcher_soft_start ##1 !switcher_soft_start)
    else $error("soft start pulse missing or too long");
  thermal_off_a: assert property (junction_above_shutdown |-> ##2 !any_on)
    else $error("channel on during thermal shutdown");
  thermal_hold_a: assert property (junction_above_shutdown ##1 !junction_below_recovery [*2] |=> !any_on)
    else $error("channel back on before cooling");
  uvlo_off_a: assert property (supply_below_std_trip |-> ##2 !any_on)
    else $error("channel on during lockout");
  uvlo_stage_a: assert property (supply_below_std_trip |=> !main_switch_enable && !sync_rect_enable)
    else $error("power stage live during lockout");
  // ============================================================
  // Switching mode
  forced_mode_a: assert property (mode_in |=> forced_pwm && !burst_mode)
    else $error("forced mode not applied");
  burst_cause_a: assert property (burst_mode |-> $past(light_load_in) && !$past(mode_in))
    else $error("burst without light load in auto mode");
endmodule
`default_nettype wire

/* tb/tb_regulator_enable_sequencer.sv */
`default_nettype none
module tb_regulator_enable_sequencer;
  import pmu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = 20;
  logic        clk = 1'b0, resetn = 1'b0, hwrite = 1'b0, mode_in = 1'b0;
  logic        light_load_in = 1'b0, power_cycle_event = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [2:0]  en_cmd = 3'h7;
  int          temp_c = 25, supply_mv = 3300, failures = 0, total_checks = 0, cyc = 0;
  int          ss_cnt[3] = '{0, 0, 0}, rise_t[3];
  logic        hreadyout, hresp, switcher_on, linear_reg_a_on, linear_reg_b_on, irq;
  logic        switcher_soft_start, linear_reg_a_soft_start, linear_reg_b_soft_start;
  logic        main_switch_enable, sync_rect_enable, forced_pwm, burst_mode;
  logic        switcher_enable_in, linear_a_enable_in, linear_b_enable_in;
  logic        junction_above_shutdown, junction_below_recovery;
  logic        supply_below_std_trip, supply_below_high_trip;
  wire [2:0]   on = {linear_reg_b_on, linear_reg_a_on, switcher_on};
  wire [2:0]   ss = {linear_reg_b_soft_start, linear_reg_a_soft_start, switcher_soft_start};
  always #5 clk = ~clk;
  host_model host_model_i (.clk, .en_cmd, .temp_c, .supply_mv, .switcher_enable_in, .linear_a_enable_in,
    .linear_b_enable_in, .junction_above_shutdown, .junction_below_recovery, .supply_below_std_trip,
    .supply_below_high_trip);
  regulator_enable_sequencer #(.GAP_CYCLES(GAP)) regulator_enable_sequencer_i (.clk, .resetn, .hsel(1'b1),
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .switcher_enable_in, .linear_a_enable_in, .linear_b_enable_in, .mode_in, .light_load_in,
    .junction_above_shutdown, .junction_below_recovery, .supply_below_std_trip, .supply_below_high_trip,
    .power_cycle_event, .switcher_on, .linear_reg_a_on, .linear_reg_b_on, .switcher_soft_start,
    .linear_reg_a_soft_start, .linear_reg_b_soft_start, .main_switch_enable, .sync_rect_enable,
    .forced_pwm, .burst_mode, .irq);
  // ============================================================
  // Soft start monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++) begin
      if (ss[i] === 1'b1) begin
        ss_cnt[i]++;
        rise_t[i] = cyc;
      end
    end
  end
  // ============================================================
  // Tasks
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    int t = 0;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++t < 50);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++t < 100);
    r = hrdata;
    if (t >= 100) begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  task automatic done(string n);
    $display("test %s finished", n);
  endtask
  function automatic int step_of(logic [1:0] o, int c);
    case (o)
      ORDER_A_B_SW: return c == CH_LINEAR_A ? 0 : c == CH_LINEAR_B ? 1 : 2;
      ORDER_SW_A_B: return c;
      ORDER_A_SW_B: return c == CH_LINEAR_A ? 0 : c == CH_SWITCHER ? 1 : 2;
      default: return 0;
    endcase
  endfunction
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100us;
    failures++;
    give_verdict();
  end
  // ============================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    int seed = 32'hb7ec;
    int base, c0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, CONTROL_OFFSET, 0, r);
    chk("control reset", r, 32'h0);
    bus(1'b0, MASK_OFFSET, 0, r);
    chk("mask reset", r, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    bus(1'b0, 8'h10, 0, r);
    chk("unmapped", r, 32'h0);
    chk("okay", hresp, 1'b0);
    done("registers");
    for (int i = 0; i < 16; i++) begin
      en_cmd <= 3'($random(seed));
      mode_in <= 1'($random(seed));
      light_load_in <= 1'($random(seed));
      repeat (3) @(posedge clk);
      chk("channels", on, en_cmd);
      chk("forced", forced_pwm, mode_in);
      chk("burst", burst_mode, !mode_in && light_load_in && en_cmd[0]);
    end
    done("enables");
    en_cmd <= 3'h7;
    temp_c <= 160;
    settle();
    chk("hot", on, 3'h0);
    bus(1'b0, STATUS_OFFSET, 0, r);
    chk("thermal flag", r[STAT_THERMAL_BIT], 1'b1);
    chk("irq masked", irq, 1'b0);
    wr(MASK_OFFSET, MASK_SWITCHER);
    settle();
    chk("irq", irq, 1'b1);
    temp_c <= 140;
    settle();
    chk("hysteresis", on, 3'h0);
    c0 = ss_cnt[0] + ss_cnt[1] + ss_cnt[2];
    temp_c <= 25;
    settle();
    chk("cooled", on, 3'h7);
    chk("fresh ramps", ss_cnt[0] + ss_cnt[1] + ss_cnt[2] - c0, 3);
    wr(EVENT_OFFSET, 32'h1);
    settle();
    chk("irq cleared", irq, 1'b0);
    done("thermal");
    supply_mv <= 2000;
    settle();
    chk("lockout", on, 3'h0);
    chk("stage", {main_switch_enable, sync_rect_enable}, 2'h0);
    supply_mv <= 3300;
    settle();
    chk("unlocked", on, 3'h7);
    wr(CONTROL_OFFSET, 32'h1);
    supply_mv <= 3000;
    settle();
    chk("high trip", on, 3'h0);
    supply_mv <= 4000;
    settle();
    chk("high clear", on, 3'h7);
    done("lockout");
    for (int o = 0; o < 4; o++) begin
      wr(CONTROL_OFFSET, 32'(o) << CTRL_ORDER_LSB);
      en_cmd <= 3'h0;
      settle();
      en_cmd <= (o == 1) ? 3'h5 : 3'h7;
      power_cycle_event <= 1'b1;
      foreach (rise_t[i]) rise_t[i] = -1;
      @(posedge clk);
      power_cycle_event <= 1'b0;
      repeat (3 * GAP + 10) @(posedge clk);
      for (int c = 0; c < 3; c++) if (step_of(2'(o), c) == 0) base = rise_t[c];
      for (int c = 0; c < 3; c++) begin
        c0 = (o == 1 && c == CH_LINEAR_A) ? -1 : base + step_of(2'(o), c) * GAP;
        chk("start time", rise_t[c], c0);
      end
      bus(1'b0, EVENT_OFFSET, 0, r);
      chk("restart event", r[EV_RESTART_BIT], 1'b1);
      wr(EVENT_OFFSET, 32'h4);
    end
    done("restart");
    give_verdict();
  end
endmodule
bind regulator_enable_sequencer res_checker res_checker_i (.clk, .resetn, .switcher_enable_in, .mode_in,
  .light_load_in, .junction_above_shutdown, .junction_below_recovery, .supply_below_std_trip, .switcher_on,
  .linear_reg_a_on, .linear_reg_b_on, .switcher_soft_start, .main_switch_enable, .sync_rect_enable,
  .forced_pwm, .burst_mode);
`default_nettype wire
